// ==== src/iopfs_defines.svh ====
// Constants for the port pin function select block: line count, config codes, reset values.
// Assumes inclusion by bare name from package and modules.
// Functional notes
// - 28 port lines, each input, output, bidirectional or alternate function.
// - Standard lines let software pick TTL or CMOS input threshold.
// - Port 2 bits 1,0 always use Schmitt trigger input, ignoring selection; padSchmitt is low from reset to the first clock edge after it.
// - Only port3_bit7 has a weak pull-up, enabled or disabled by software.
// - Pull-up requests on other lines have no effect.
// - Reset: port3_bit7 alternate function, push-pull, TTL.
// - Reset: other lines bidirectional, open drain, TTL.
// - At most one alternate function drives any pin at a time.
// - Alternate inputs connect implicitly when their peripheral is enabled.
// - Port 4 alternate outputs carry PWM channels 0..7 in order.
// - port3_bit7 alternate function drives internal_reset_out.
`ifndef IOPFS_DEFINES_SVH
`define IOPFS_DEFINES_SVH
`define IOPFS_NLINES 28
`define IOPFS_AWIDTH 3
// Register indices: 0..2 config bits 0..2, 3 data, 4 pull-up enable, 5 pin level (read only)
`define IOPFS_REG_CFG0 3'h0
`define IOPFS_REG_CFG1 3'h1
`define IOPFS_REG_CFG2 3'h2
`define IOPFS_REG_DATA 3'h3
`define IOPFS_REG_PULL 3'h4
`define IOPFS_REG_PIN 3'h5
// Line index of port3_bit7, of the two Schmitt lines and of port 4 bit 0
`define IOPFS_IDX_P37 5'h0f
`define IOPFS_IDX_P20 5'h08
`define IOPFS_IDX_P21 5'h09
`define IOPFS_IDX_P40 5'h10
// Reset values: bidirectional open drain TTL = 0,0,0 except port3_bit7 alt push-pull 0,1,1
`define IOPFS_RST_CFG0 28'h0008000
`define IOPFS_RST_CFG1 28'h0008000
`define IOPFS_RST_CFG2 28'h0000000
`define IOPFS_RST_DATA 28'hfffffff
`define IOPFS_RST_PULL 28'h0000000
// Config codes {cfg2,cfg1,cfg0}
`define IOPFS_C_IN_TTL 3'h5
`define IOPFS_C_IN_CMOS 3'h4
`define IOPFS_C_OUT_OD 3'h2
`define IOPFS_C_OUT_PP 3'h6
`define IOPFS_C_AF_OD 3'h1
`define IOPFS_C_AF_PP 3'h3
`define IOPFS_C_ANALOG 3'h7
`define IOPFS_C_BID 3'h0
`endif

// ==== src/iopfs_pkg.sv ====
// Types for the port pin function select block.
// Assumes the defines header is on the include path.
`include "iopfs_defines.svh"
package iopfs_pkg;
   typedef logic [`IOPFS_NLINES-1:0] iopfs_vec_t;
   typedef enum logic [1:0] {IOPFS_DIR_IN, IOPFS_DIR_OUT, IOPFS_DIR_BID} iopfs_dir_t;
endpackage

// ==== src/iopfs_cfg_if.sv ====
// Decoded per-line configuration carried from the register file to the pin logic.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface iopfs_cfg_if;
   import iopfs_pkg::*;
   iopfs_vec_t drvEn;
   iopfs_vec_t pushPull;
   iopfs_vec_t altSel;
   iopfs_vec_t cmosSel;
   iopfs_vec_t analogSel;
   iopfs_vec_t dataBit;
   iopfs_vec_t pullEn;
   modport src (output drvEn, pushPull, altSel, cmosSel, analogSel, dataBit, pullEn);
   modport dst (input drvEn, pushPull, altSel, cmosSel, analogSel, dataBit, pullEn);
endinterface
`default_nettype wire

// ==== src/iopfs_line_cfg.sv ====
// Decodes the three config bit vectors into per-line mode signals.
// Assumes register vectors come from flops of the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "iopfs_defines.svh"
module iopfs_line_cfg
   import iopfs_pkg::*;
(
   input wire logic [`IOPFS_NLINES-1:0] cfg0,
   input wire logic [`IOPFS_NLINES-1:0] cfg1,
   input wire logic [`IOPFS_NLINES-1:0] cfg2,
   input wire logic [`IOPFS_NLINES-1:0] dataReg,
   input wire logic [`IOPFS_NLINES-1:0] pullReg,
   iopfs_cfg_if.src cfg
);
   genvar i;
   // One decoder per line
   generate
      for (i = 0; i < `IOPFS_NLINES; i++) begin : g_line
         logic [2:0] code;
         assign code = {cfg2[i], cfg1[i], cfg0[i]};
         // Output codes and bidirectional enable the driver
         assign cfg.drvEn[i] = (code == `IOPFS_C_OUT_OD) || (code == `IOPFS_C_OUT_PP) ||
            (code == `IOPFS_C_AF_OD) || (code == `IOPFS_C_AF_PP) ||
            (code == `IOPFS_C_BID);
         assign cfg.pushPull[i] = (code == `IOPFS_C_OUT_PP) || (code == `IOPFS_C_AF_PP);
         // Alt output only by explicit selection, never by peripheral enable
         assign cfg.altSel[i] = (code == `IOPFS_C_AF_OD) || (code == `IOPFS_C_AF_PP);
         assign cfg.cmosSel[i] = (code == `IOPFS_C_IN_CMOS);
         assign cfg.analogSel[i] = (code == `IOPFS_C_ANALOG);
         assign cfg.dataBit[i] = dataReg[i];
         // Pull-up exists only on port3_bit7
         assign cfg.pullEn[i] = (i == `IOPFS_IDX_P37) ? pullReg[i] : 1'b0;
      end
   endgenerate
endmodule // iopfs_line_cfg
`default_nettype wire

// ==== src/iopfs_alt_mux.sv ====
// Picks the single alternate output for each line from the peripheral signals.
// Assumes peripherals drive their signals on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "iopfs_defines.svh"
module iopfs_alt_mux
   import iopfs_pkg::*;
(
   input wire logic [7:0] pwmOut,
   input wire logic internalResetOut,
   input wire logic [`IOPFS_NLINES-1:0] otherAltOut,
   output logic [`IOPFS_NLINES-1:0] altOut
);
   genvar i;
   // Fixed one-function-per-line map; a pin never sees two sources
   generate
      for (i = 0; i < `IOPFS_NLINES; i++) begin : g_alt
         // Only the eight port 4 lines carry PWM; port 5 and above keep their own source
         if (i >= `IOPFS_IDX_P40 && i < `IOPFS_IDX_P40 + 8) begin : g_pwm
            assign altOut[i] = pwmOut[i-`IOPFS_IDX_P40];
         end else if (i == `IOPFS_IDX_P37) begin : g_rst
            assign altOut[i] = internalResetOut;
         end else begin : g_oth
            assign altOut[i] = otherAltOut[i];
         end
      end
   endgenerate
endmodule // iopfs_alt_mux
`default_nettype wire

// ==== src/iopfs_top.sv ====
// Top of the pin function select block: register port, pin drivers, input sync.
// Assumes one core clock; pins are resolved outside from out/oe. Line index order:
// port 0 is 0..7, port 2 is 8..13, port 3 bit 4 is 14, port3_bit7 is 15,
// port 4 is 16..23, port 5 is 24..25, port 3 bits 5 and 6 are 26..27.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iopfs_defines.svh"
module iopfs_top
   import iopfs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [`IOPFS_AWIDTH-1:0] regAddr,
   input wire logic [`IOPFS_NLINES-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [`IOPFS_NLINES-1:0] regRdata,
   input wire logic [7:0] pwmOut,
   input wire logic internalResetOut,
   input wire logic [`IOPFS_NLINES-1:0] otherAltOut,
   input wire logic [`IOPFS_NLINES-1:0] periphEn,
   input wire logic [`IOPFS_NLINES-1:0] padIn,
   output logic [`IOPFS_NLINES-1:0] padOut,
   output logic [`IOPFS_NLINES-1:0] padOe,
   output logic [`IOPFS_NLINES-1:0] padPullEn,
   output logic [`IOPFS_NLINES-1:0] padCmosSel,
   output logic [`IOPFS_NLINES-1:0] padSchmitt,
   output logic [`IOPFS_NLINES-1:0] padAnalogEn,
   output logic [`IOPFS_NLINES-1:0] altIn,
   output logic [`IOPFS_NLINES-1:0] gpIn
);
   localparam iopfs_vec_t SCHMITT = (28'h1 << `IOPFS_IDX_P20) | (28'h1 << `IOPFS_IDX_P21);

   // Software-visible registers and read data
   iopfs_vec_t cfg0_ff, cfg1_ff, cfg2_ff, data_ff, pull_ff, rd_ff;
   iopfs_vec_t nxt_cfg0, nxt_cfg1, nxt_cfg2, nxt_data, nxt_pull, nxt_rd;
   // Two-stage pin synchroniser
   iopfs_vec_t syncA_ff, syncB_ff;
   // Pad control flops and their next values
   iopfs_vec_t out_ff, oe_ff, pu_ff, cm_ff, sc_ff, an_ff, ai_ff;
   iopfs_vec_t nxt_out, nxt_oe, nxt_pu, nxt_cm, nxt_sc, nxt_an, nxt_ai;
   // Alternate outputs and decoded configuration
   iopfs_vec_t altOut;
   iopfs_cfg_if cfg ();

   iopfs_line_cfg u_cfg (
      .cfg0(cfg0_ff),
      .cfg1(cfg1_ff),
      .cfg2(cfg2_ff),
      .dataReg(data_ff),
      .pullReg(pull_ff),
      .cfg(cfg)
   );

   iopfs_alt_mux u_mux (
      .pwmOut(pwmOut),
      .internalResetOut(internalResetOut),
      .otherAltOut(otherAltOut),
      .altOut(altOut)
   );

   // Register port: writes land next edge, reads answer the following cycle
   always_comb begin
      nxt_cfg0 = cfg0_ff;
      nxt_cfg1 = cfg1_ff;
      nxt_cfg2 = cfg2_ff;
      nxt_data = data_ff;
      nxt_pull = pull_ff;
      nxt_rd = '0;
      if (regWr) begin
         unique case (regAddr)
            `IOPFS_REG_CFG0: nxt_cfg0 = regWdata;
            `IOPFS_REG_CFG1: nxt_cfg1 = regWdata;
            `IOPFS_REG_CFG2: nxt_cfg2 = regWdata;
            `IOPFS_REG_DATA: nxt_data = regWdata;
            `IOPFS_REG_PULL: nxt_pull = regWdata;
            default: ;
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            `IOPFS_REG_CFG0: nxt_rd = cfg0_ff;
            `IOPFS_REG_CFG1: nxt_rd = cfg1_ff;
            `IOPFS_REG_CFG2: nxt_rd = cfg2_ff;
            `IOPFS_REG_DATA: nxt_rd = data_ff;
            `IOPFS_REG_PULL: nxt_rd = pull_ff;
            `IOPFS_REG_PIN: nxt_rd = syncB_ff;
            default: nxt_rd = '0; // Unmapped reads give zero
         endcase
      end
   end

   // Register state; reset codes put port3_bit7 in alt push-pull, the rest bidir open drain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg0_ff <= `IOPFS_RST_CFG0;
         cfg1_ff <= `IOPFS_RST_CFG1;
         cfg2_ff <= `IOPFS_RST_CFG2;
         data_ff <= `IOPFS_RST_DATA;
         pull_ff <= `IOPFS_RST_PULL;
         rd_ff <= '0;
      end else begin
         cfg0_ff <= nxt_cfg0;
         cfg1_ff <= nxt_cfg1;
         cfg2_ff <= nxt_cfg2;
         data_ff <= nxt_data;
         pull_ff <= nxt_pull;
         rd_ff <= nxt_rd;
      end
   end

   // Pin drive: open drain enables only for a zero, push-pull drives both
   always_comb begin
      iopfs_vec_t val;
      val = '0;
      nxt_out = '0;
      nxt_oe = '0;
      for (int k = 0; k < `IOPFS_NLINES; k++) begin
         val[k] = cfg.altSel[k] ? altOut[k] : cfg.dataBit[k];
         nxt_out[k] = val[k];
         if (cfg.drvEn[k]) begin
            nxt_oe[k] = cfg.pushPull[k] | ~val[k];
         end
      end
      nxt_pu = cfg.pullEn;
      nxt_cm = cfg.cmosSel & ~SCHMITT;
      nxt_sc = SCHMITT;
      nxt_an = cfg.analogSel;
      // Alt inputs follow the synced pin whenever the peripheral is enabled
      nxt_ai = syncB_ff & periphEn;
   end

   // Pad controls are registered so every output leaves a flop
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_ff <= '0;
         syncB_ff <= '0;
         out_ff <= '1;
         oe_ff <= '0;
         pu_ff <= '0;
         cm_ff <= '0;
         sc_ff <= '0;
         an_ff <= '0;
         ai_ff <= '0;
      end else begin
         syncA_ff <= padIn;
         syncB_ff <= syncA_ff;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         pu_ff <= nxt_pu;
         cm_ff <= nxt_cm;
         sc_ff <= nxt_sc;
         an_ff <= nxt_an;
         ai_ff <= nxt_ai;
      end
   end

   assign regRdata = rd_ff;
   assign padOut = out_ff;
   assign padOe = oe_ff;
   assign padPullEn = pu_ff;
   assign padCmosSel = cm_ff;
   assign padSchmitt = sc_ff;
   assign padAnalogEn = an_ff;
   assign altIn = ai_ff;
   assign gpIn = syncB_ff;

   // Checks
   property p_rd_latency;
      @(posedge core_clk) disable iff (!rst_n)
      regRd && regAddr == `IOPFS_REG_DATA && !regWr |=> regRdata == $past(data_ff);
   endproperty
   a_rd_latency: assert property (p_rd_latency) else $error("read data wrong");
   property p_schmitt;
      @(posedge core_clk) disable iff (!rst_n)
      ##1 !padCmosSel[`IOPFS_IDX_P20] && !padCmosSel[`IOPFS_IDX_P21];
   endproperty
   a_schmitt: assert property (p_schmitt) else $error("schmitt line took cmos");
   property p_cmos;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.cmosSel[3] |=> padCmosSel[3];
   endproperty
   a_cmos: assert property (p_cmos) else $error("cmos select lost");
   property p_nopull;
      @(posedge core_clk) disable iff (!rst_n)
      padPullEn[0] == 1'b0 && padPullEn[`IOPFS_IDX_P40] == 1'b0;
   endproperty
   a_nopull: assert property (p_nopull) else $error("pull-up on line without one");
   property p_pull37;
      @(posedge core_clk) disable iff (!rst_n)
      pull_ff[`IOPFS_IDX_P37] |=> padPullEn[`IOPFS_IDX_P37];
   endproperty
   a_pull37: assert property (p_pull37) else $error("pull-up not applied");
   property p_pwm_output_zero;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.altSel[`IOPFS_IDX_P40] |=> padOut[`IOPFS_IDX_P40] == $past(pwmOut[0]);
   endproperty
   a_pwm_output_zero: assert property (p_pwm_output_zero) else $error("pwm_output_zero not routed");
   property p_rst37;
      @(posedge core_clk) disable iff (!rst_n)
      rst_n && cfg.altSel[`IOPFS_IDX_P37] |=> padOut[`IOPFS_IDX_P37] == $past(internalResetOut);
   endproperty
   a_rst37: assert property (p_rst37) else $error("reset out not routed");
   property p_gpout;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.drvEn[1] && !cfg.altSel[1] |=> padOut[1] == $past(data_ff[1]);
   endproperty
   a_gpout: assert property (p_gpout) else $error("gp output not from data");
   property p_od;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.drvEn[2] && !cfg.pushPull[2] && data_ff[2] && !cfg.altSel[2] |=> !padOe[2];
   endproperty
   a_od: assert property (p_od) else $error("open drain drove a one");
   property p_altin;
      @(posedge core_clk) disable iff (!rst_n)
      !periphEn[3] |=> !altIn[3];
   endproperty
   a_altin: assert property (p_altin) else $error("alt input without peripheral");

   // Register port checks
   property p_rd_cfg2;
      @(posedge core_clk) disable iff (!rst_n)
      regRd && regAddr == `IOPFS_REG_CFG2 && !regWr |=> regRdata == $past(cfg2_ff);
   endproperty
   a_rd_cfg2: assert property (p_rd_cfg2) else $error("config readback wrong");
   property p_rd_pin;
      @(posedge core_clk) disable iff (!rst_n)
      regRd && regAddr == `IOPFS_REG_PIN |=> regRdata == $past(syncB_ff);
   endproperty
   a_rd_pin: assert property (p_rd_pin) else $error("pin level readback wrong");
   property p_rd_idle;
      @(posedge core_clk) disable iff (!rst_n)
      !regRd |=> regRdata == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_wr_data;
      @(posedge core_clk) disable iff (!rst_n)
      regWr && regAddr == `IOPFS_REG_DATA |=> data_ff == $past(regWdata);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("data write lost");
   property p_wr_pull;
      @(posedge core_clk) disable iff (!rst_n)
      regWr && regAddr == `IOPFS_REG_PULL |=> pull_ff == $past(regWdata);
   endproperty
   a_wr_pull: assert property (p_wr_pull) else $error("pull-up write lost");

   // Pin drive and input checks
   property p_pp_drive;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.drvEn[0] && cfg.pushPull[0] |=> padOe[0];
   endproperty
   a_pp_drive: assert property (p_pp_drive) else $error("push-pull released the pin");
   property p_od_low;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.drvEn[2] && !cfg.pushPull[2] && !cfg.altSel[2] && !data_ff[2] |=> padOe[2] && !padOut[2];
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain did not pull low");
   property p_analog;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.analogSel[10] |=> padAnalogEn[10] && !padOe[10];
   endproperty
   a_analog: assert property (p_analog) else $error("analog line not connected");
   property p_other_alt;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.altSel[24] |=> padOut[24] == $past(otherAltOut[24]);
   endproperty
   a_other_alt: assert property (p_other_alt) else $error("wrong alternate source");
   property p_pwm7;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.altSel[23] |=> padOut[23] == $past(pwmOut[7]);
   endproperty
   a_pwm7: assert property (p_pwm7) else $error("pwm7 not routed");
   property p_altin_on;
      @(posedge core_clk) disable iff (!rst_n)
      rst_n && periphEn[5] |=> altIn[5] == $past(syncB_ff[5]);
   endproperty
   a_altin_on: assert property (p_altin_on) else $error("alt input not connected");
   property p_ttl;
      @(posedge core_clk) disable iff (!rst_n)
      !cfg.cmosSel[4] |=> !padCmosSel[4];
   endproperty
   a_ttl: assert property (p_ttl) else $error("ttl line took cmos");
   property p_gpin;
      @(posedge core_clk) disable iff (!rst_n)
      rst_n ##1 rst_n |=> gpIn == $past(padIn, 2);
   endproperty
   a_gpin: assert property (p_gpin) else $error("input sync wrong");

   // Reset checks; no disable here, the release edge itself is the trigger
   property p_rst37cfg;
      @(posedge core_clk)
      !rst_n ##1 rst_n |-> cfg.altSel[15] && cfg.pushPull[15] && !cfg.cmosSel[15];
   endproperty
   a_rst37cfg: assert property (p_rst37cfg) else $error("reset line 15 config wrong");
   property p_rstbid;
      @(posedge core_clk)
      !rst_n ##1 rst_n |-> cfg.drvEn[0] && !cfg.pushPull[0] && !cfg.altSel[0] && !cfg.cmosSel[0];
   endproperty
   a_rstbid: assert property (p_rstbid) else $error("reset line 0 config wrong");
   c_pwm: cover property (@(posedge core_clk) disable iff (!rst_n) cfg.altSel[`IOPFS_IDX_P40]);
   c_wr: cover property (@(posedge core_clk) disable iff (!rst_n) regWr ##1 regRd);
   c_an: cover property (@(posedge core_clk) disable iff (!rst_n) padAnalogEn[10]);
   c_alt24: cover property (@(posedge core_clk) disable iff (!rst_n) cfg.altSel[24]);
   c_pull: cover property (@(posedge core_clk) disable iff (!rst_n) padPullEn[`IOPFS_IDX_P37]);
endmodule // iopfs_top
`default_nettype wire

// ==== bench/iopfs_partner.sv ====
// Model of the peripherals and the board seen from the pin function select block.
// Assumes the bench commands peripheral levels; pad levels are resolved here.
`timescale 1ns/1ps
`default_nettype none
`include "iopfs_defines.svh"
module iopfs_partner
   import iopfs_pkg::*;
(
   input wire logic [7:0] pwmPat,
   input wire logic rstPat,
   input wire iopfs_vec_t otherPat,
   input wire iopfs_vec_t enPat,
   input wire iopfs_vec_t boardLvl,
   input wire iopfs_vec_t padOut,
   input wire iopfs_vec_t padOe,
   input wire iopfs_vec_t padPullEn,
   output logic [7:0] pwmOut,
   output logic internalResetOut,
   output iopfs_vec_t otherAltOut,
   output iopfs_vec_t periphEn,
   output iopfs_vec_t padIn
);
   // Peripheral levels follow the bench, so expectations are known up front
   assign pwmOut = pwmPat;
   assign internalResetOut = rstPat;
   assign otherAltOut = otherPat; // Alternate sources for lines outside port 4 and port3_bit7
   assign periphEn = enPat;

   // Pin level: block driver wins, then the pull-up, then the board
   always_comb begin
      for (int i = 0; i < `IOPFS_NLINES; i++) begin
         padIn[i] = padOe[i] ? padOut[i] : (padPullEn[i] ? 1'b1 : boardLvl[i]);
      end
   end
endmodule // iopfs_partner
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the pin function select block.
// Assumes the design package, defines header and partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "iopfs_defines.svh"
module testbench;
   import iopfs_pkg::*;
   typedef struct packed {logic [4:0] ln; logic [2:0] code; logic d; logic [7:0] pwm;
      logic rstO; logic oth; logic eOe; logic eOut; logic eCmos;} iopfs_row_t;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic rstPat = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] pwmPat = 8'h00;
   logic [7:0] pwmOut;
   logic internalResetOut;
   iopfs_vec_t regWdata = 28'h0, otherPat = 28'h0, enPat = 28'h0, boardLvl = 28'h0;
   iopfs_vec_t regRdata, otherAltOut, periphEn, padIn, padOut, padOe, padPullEn;
   iopfs_vec_t padCmosSel, padSchmitt, padAnalogEn, altIn, gpIn, v;
   iopfs_vec_t sh [4];
   int nFail = 0;
   int nCompared = 0;
   // Line, code, data, pwm, reset out, other alt, expected oe, out, cmos
   iopfs_row_t rows [13] = '{
      '{5'h00, 3'h6, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{5'h00, 3'h6, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
      '{5'h01, 3'h2, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{5'h01, 3'h2, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{5'h10, 3'h3, 1'b1, 8'hfe, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
      '{5'h17, 3'h3, 1'b0, 8'h80, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
      '{5'h14, 3'h3, 1'b0, 8'h10, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0},
      '{5'h0f, 3'h1, 1'b1, 8'hff, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
      '{5'h0f, 3'h1, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
      '{5'h02, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{5'h03, 3'h4, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
      '{5'h08, 3'h4, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{5'h18, 3'h3, 1'b0, 8'hff, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}};

   iopfs_top dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .pwmOut(pwmOut), .internalResetOut(internalResetOut), .otherAltOut(otherAltOut),
      .periphEn(periphEn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
      .padPullEn(padPullEn), .padCmosSel(padCmosSel), .padSchmitt(padSchmitt),
      .padAnalogEn(padAnalogEn), .altIn(altIn), .gpIn(gpIn));
   iopfs_partner partner (.pwmPat(pwmPat), .rstPat(rstPat), .otherPat(otherPat),
      .enPat(enPat), .boardLvl(boardLvl), .padOut(padOut), .padOe(padOe),
      .padPullEn(padPullEn), .pwmOut(pwmOut), .internalResetOut(internalResetOut),
      .otherAltOut(otherAltOut), .periphEn(periphEn), .padIn(padIn));

   always #5 core_clk = ~core_clk;

   // Single comparison point, counts every check
   task automatic chk(input string nm, input iopfs_vec_t seen, input iopfs_vec_t exp);
      nCompared++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input iopfs_vec_t d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output iopfs_vec_t d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   // Whole words are rewritten, so a shadow keeps the other lines intact
   task automatic setLine(input int i, input logic [2:0] c, input logic d);
      sh[0][i] = c[0];
      sh[1][i] = c[1];
      sh[2][i] = c[2];
      sh[3][i] = d;
      for (int k = 0; k < 4; k++) wr(3'(k), sh[k]);
      @(posedge core_clk);
      #1;
   endtask
   // Reset and the values every line must come up with
   task automatic doReset();
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      sh = '{`IOPFS_RST_CFG0, `IOPFS_RST_CFG1, `IOPFS_RST_CFG2, `IOPFS_RST_DATA};
      repeat (2) @(posedge core_clk);
      #1;
      chk("padOe", padOe, 28'h0008000);
      chk("padOut15", 28'(padOut[15]), 28'(rstPat));
      chk("padCmosSel", padCmosSel, 28'h0);
      chk("padSchmitt", 28'(padSchmitt[9:8]), 28'h3);
      $display("reset test done");
   endtask
   task automatic finish_test();
      $display("compared %0d failed %0d", nCompared, nFail);
      if (nFail == 0 && nCompared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog against a hung sequence
   initial begin
      #500000;
      nFail++;
      finish_test();
   end

   initial begin
      doReset();
      foreach (rows[r]) begin
         pwmPat <= rows[r].pwm;
         rstPat <= rows[r].rstO;
         otherPat <= {28{rows[r].oth}};
         setLine(rows[r].ln, rows[r].code, rows[r].d);
         chk("padOe", 28'(padOe[rows[r].ln]), 28'(rows[r].eOe));
         if (rows[r].eOe) chk("padOut", 28'(padOut[rows[r].ln]), 28'(rows[r].eOut));
         chk("padCmosSel", 28'(padCmosSel[rows[r].ln]), 28'(rows[r].eCmos));
         $display("row %0d done", r);
      end
      // Pull-up exists on one line only
      wr(`IOPFS_REG_PULL, 28'hfffffff);
      @(posedge core_clk);
      #1 chk("padPullEn", padPullEn, 28'h0008000);
      wr(`IOPFS_REG_PULL, 28'h0);
      @(posedge core_clk);
      #1 chk("padPullEn", padPullEn, 28'h0);
      $display("pull test done");
      // Inputs: general purpose path and implicit peripheral connection
      boardLvl <= 28'h0000020;
      enPat <= 28'h0000020;
      setLine(5, 3'h5, 1'b1);
      repeat (3) @(posedge core_clk);
      #1 chk("gpIn", 28'(gpIn[5]), 28'h1);
      chk("altIn", 28'(altIn[5]), 28'h1);
      rd(`IOPFS_REG_PIN, v);
      chk("pinReg", 28'(v[5]), 28'h1);
      enPat <= 28'h0;
      repeat (2) @(posedge core_clk);
      #1 chk("altIn", 28'(altIn[5]), 28'h0);
      $display("input test done");
      // Analog connect only through explicit configuration
      enPat <= 28'hfffffff;
      setLine(10, 3'h5, 1'b1);
      chk("padAnalogEn", 28'(padAnalogEn[10]), 28'h0);
      setLine(10, 3'h7, 1'b1);
      chk("padAnalogEn", 28'(padAnalogEn[10]), 28'h1);
      chk("padOe", 28'(padOe[10]), 28'h0);
      $display("analog test done");
      // Read back and an unmapped register
      rd(`IOPFS_REG_CFG2, v);
      chk("cfg2", v, sh[2]);
      rd(3'h7, v);
      chk("unmapped", v, 28'h0);
      rstPat <= 1'b0;
      doReset();
      finish_test();
   end
endmodule // testbench
`default_nettype wire
